// ==== ext_irq_pkg.sv ====
// Purpose: shared constants and types for the external interrupt sensitivity block
// Assumes: 8-bit register port, one 100 MHz clock, synchronous active-low reset
// Notes: register offsets are byte addresses on the plain register port
//
// Overview of operation
// [RL1] the control register is read/write and clears to zero on reset.
// [RL2] the top two bits of the control register pick the trigger of both port B sources.
// [RL3] uninverted codes: 00 falling edge plus low level, 01 rising, 10 falling, 11 both edges.
// [RL4] port B polarity set inverts the low port B trigger, both-edges staying unchanged.
// [RL5] inversion touches only the low-nibble groups; port B high and port F stay uninverted.
// [RL6] bits four and three pick the trigger of the port A and port F sources.
// [RL7] the port A polarity bit at bit two inverts the port A trigger likewise.
// [RL8] sensitivity fields and polarity bits take writes only at CPU priority level 3.
// [RL9] bit one picks the top-level pin edge and is writable only while its enable is clear.
// [RL10] bit zero enables the top-level pin interrupt and is freely writable.
// [RL11] writing a changed sensitivity or polarity value clears pending port group requests; the top-level pin request is kept.
// [RL12] a priority pair written as code 10 is refused and the old pair is kept.
// [RL13] a gated field written while locked stays put while ungated bits still update.
// [RL14] pins are synchronised and edges found by comparing current and previous samples.
package ext_irq_pkg;
	localparam logic [7:0] OFS_PRIO_0 = 8'h24;
	localparam logic [7:0] OFS_PRIO_1 = 8'h25;
	localparam logic [7:0] OFS_PRIO_2 = 8'h26;
	localparam logic [7:0] OFS_PRIO_3 = 8'h27;
	localparam logic [7:0] OFS_CONTROL = 8'h28;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h29;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2a;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] PRIO_RESET = 8'hff;
	localparam logic [7:0] PRIO3_FIXED = 8'hf0; // upper bits of priority 3 read one
	localparam logic [7:0] GATED_MASK = 8'hfc; // fields locked outside level 3
	localparam logic [1:0] LEVEL_3 = 2'h3;
	localparam logic [1:0] PAIR_LEVEL_0 = 2'h2;
	localparam int NUM_SOURCES = 5;
	localparam int BIT_TOP_EN = 0;
	localparam int BIT_TOP_EDGE = 1;
	localparam int BIT_POL_A = 2;
	localparam int BIT_SEL_AF = 3;
	localparam int BIT_POL_B = 5;
	localparam int BIT_SEL_B = 6;
	typedef enum logic [1:0] {
		TRIG_FALL_LOW = 2'b00,
		TRIG_RISE = 2'b01,
		TRIG_FALL = 2'b10,
		TRIG_BOTH = 2'b11
	} trig_type;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
endpackage

// ==== pin_sync.sv ====
// Purpose: two-stage synchroniser with edge outputs for a group of pins
// Assumes: one clock, synchronous active-low reset
// Notes: the first stage is read by the second stage only
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise,
	output logic [WIDTH-1:0] o_fall
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] prev_r;

	// two flops then one history flop; idle pins assumed high
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			meta_r <= '1;
			sync_r <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= i_pins; // RL14
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edges from current against previous sample
	assign o_level = sync_r;
	assign o_rise = sync_r & ~prev_r; // RL14
	assign o_fall = ~sync_r & prev_r;
endmodule

// ==== trig_detect.sv ====
// Purpose: turns one pin group's samples into a trigger per the sensitivity code
// Assumes: inputs already synchronised
// Notes: any line of the group raises the trigger
`timescale 1ns/10ps
module trig_detect #(
	parameter int WIDTH = 4
) (
	input ext_irq_pkg::trig_type i_sel,
	input wire logic i_invert,
	input wire logic [WIDTH-1:0] i_level,
	input wire logic [WIDTH-1:0] i_rise,
	input wire logic [WIDTH-1:0] i_fall,
	output logic o_trig
);
	import ext_irq_pkg::*;
	wire [WIDTH-1:0] rise_eff;
	wire [WIDTH-1:0] fall_eff;
	wire [WIDTH-1:0] low_eff;

	// inversion swaps rising and falling and flips the level sense
	assign rise_eff = i_invert ? i_fall : i_rise; // RL4
	assign fall_eff = i_invert ? i_rise : i_fall;
	assign low_eff = i_invert ? i_level : ~i_level;

	// code table
	always_comb begin
		case (i_sel)
			TRIG_FALL_LOW: o_trig = |(fall_eff | low_eff); // RL3
			TRIG_RISE: o_trig = |rise_eff;
			TRIG_FALL: o_trig = |fall_eff;
			TRIG_BOTH: o_trig = |(i_rise | i_fall); // RL4
			default: o_trig = 1'b0;
		endcase
	end
endmodule

// ==== ext_irq_sense.sv ====
// Purpose: external interrupt control register, priority registers and trigger detection
// Assumes: CPU priority bits arrive as plain inputs synchronous to the clock
// Notes: pending requests are held in sticky status bits cleared by writing one
//        a hardware set in the same cycle as a clear always wins, so no event is lost
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module ext_irq_sense #(
	parameter int PA_WIDTH = 4,
	parameter int PF_WIDTH = 3,
	parameter int PBL_WIDTH = 4,
	parameter int PBH_WIDTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input ext_irq_pkg::reg_req_type i_req,
	output logic [7:0] o_rdata,
	input wire logic i_cpu_priority_high_bit,
	input wire logic i_cpu_priority_low_bit,
	input wire logic [PA_WIDTH-1:0] i_porta_pins,
	input wire logic [PF_WIDTH-1:0] i_portf_pins,
	input wire logic [PBL_WIDTH-1:0] i_portb_low_pins,
	input wire logic [PBH_WIDTH-1:0] i_portb_high_pins,
	input wire logic i_top_pin,
	output logic [ext_irq_pkg::NUM_SOURCES-1:0] o_pending,
	output logic o_irq
);
	import ext_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] control_r;
	logic [7:0] control_nxt;
	logic [7:0] prio_r [4];
	logic [7:0] prio_nxt [4];
	logic [NUM_SOURCES-1:0] status_r;
	logic [NUM_SOURCES-1:0] status_nxt;
	logic [NUM_SOURCES-1:0] mask_r;
	logic [7:0] rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// priority pair write filter: a level-0 pair keeps the old pair
	function automatic logic [7:0] prio_filter(input logic [7:0] old_v, input logic [7:0] new_v);
		logic [7:0] res;
		res = new_v;
		for (int k = 0; k < 4; k++) begin
			if (new_v[2*k +: 2] == PAIR_LEVEL_0) begin
				res[2*k +: 2] = old_v[2*k +: 2]; // RL12
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	// strobes are one cycle long and never together, so each decode is a plain compare
	wire level3 = {i_cpu_priority_high_bit, i_cpu_priority_low_bit} == LEVEL_3;
	wire wr_ctrl = i_req.wr && (i_req.addr == OFS_CONTROL);
	wire wr_stat = i_req.wr && (i_req.addr == OFS_IRQ_STATUS);
	wire wr_mask = i_req.wr && (i_req.addr == OFS_IRQ_MASK);
	wire [1:0] prio_idx = i_req.addr[1:0];
	wire wr_prio = i_req.wr && (i_req.addr[7:2] == OFS_PRIO_0[7:2]);

	////////////////////////////////////////////////////////////////////////////////
	// control write with gating
	wire [7:0] gate_ok;
	assign gate_ok[BIT_TOP_EN] = 1'b1; // RL10
	assign gate_ok[BIT_TOP_EDGE] = ~control_r[BIT_TOP_EN]; // RL9
	// sensitivity and polarity may only move while the cpu runs at level 3,
	// so a trigger condition never changes under a live interrupt
	assign gate_ok[7:2] = {6{level3}}; // RL8
	// locked bits keep their old value, open bits take the write
	assign control_nxt = wr_ctrl ? ((i_req.wdata & gate_ok) | (control_r & ~gate_ok))
		: control_r; // RL13
	// a real change of any sensitivity or polarity bit drops pending group requests, not the top-level one
	wire sense_changed = |((control_nxt ^ control_r) & GATED_MASK); // RL11

	////////////////////////////////////////////////////////////////////////////////
	// field extraction
	wire [1:0] sel_b_raw = control_r[BIT_SEL_B +: 2]; // RL2
	wire [1:0] sel_af_raw = control_r[BIT_SEL_AF +: 2]; // RL6
	trig_type sel_b;
	trig_type sel_af;
	assign sel_b = trig_type'(sel_b_raw);
	assign sel_af = trig_type'(sel_af_raw);
	wire pol_b = control_r[BIT_POL_B];
	wire pol_a = control_r[BIT_POL_A]; // RL7
	wire top_en = control_r[BIT_TOP_EN];
	wire top_rising = control_r[BIT_TOP_EDGE];

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PA_WIDTH-1:0] pa_lvl, pa_rise, pa_fall;
	logic [PF_WIDTH-1:0] pf_lvl, pf_rise, pf_fall;
	logic [PBL_WIDTH-1:0] pbl_lvl, pbl_rise, pbl_fall;
	logic [PBH_WIDTH-1:0] pbh_lvl, pbh_rise, pbh_fall;
	logic top_lvl, top_rise, top_fall;

	// group a lines
	pin_sync #(
		.WIDTH(PA_WIDTH)
	) u_sync_a (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_porta_pins),
		.o_level(pa_lvl),
		.o_rise(pa_rise),
		.o_fall(pa_fall)
	);

	// group f lines
	pin_sync #(
		.WIDTH(PF_WIDTH)
	) u_sync_f (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_portf_pins),
		.o_level(pf_lvl),
		.o_rise(pf_rise),
		.o_fall(pf_fall)
	);

	// group b low lines
	pin_sync #(
		.WIDTH(PBL_WIDTH)
	) u_sync_bl (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_portb_low_pins),
		.o_level(pbl_lvl),
		.o_rise(pbl_rise),
		.o_fall(pbl_fall)
	);

	// group b high lines
	pin_sync #(
		.WIDTH(PBH_WIDTH)
	) u_sync_bh (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_portb_high_pins),
		.o_level(pbh_lvl),
		.o_rise(pbh_rise),
		.o_fall(pbh_fall)
	);

	// dedicated top-level pin; its level output is not needed
	pin_sync #(
		.WIDTH(1)
	) u_sync_top (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_top_pin),
		.o_level(top_lvl),
		.o_rise(top_rise),
		.o_fall(top_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// trigger detectors: bit 0 group a, 1 group f, 2 group b low, 3 group b high, 4 top
	wire [NUM_SOURCES-1:0] trig;

	// group a: follows its own polarity bit
	trig_detect #(
		.WIDTH(PA_WIDTH)
	) u_det_a (
		.i_sel(sel_af),
		.i_invert(pol_a), // RL7
		.i_level(pa_lvl),
		.i_rise(pa_rise),
		.i_fall(pa_fall),
		.o_trig(trig[0])
	);

	// group f: shares the code with group a but is never inverted
	trig_detect #(
		.WIDTH(PF_WIDTH)
	) u_det_f (
		.i_sel(sel_af),
		.i_invert(1'b0), // RL5
		.i_level(pf_lvl),
		.i_rise(pf_rise),
		.i_fall(pf_fall),
		.o_trig(trig[1])
	);

	// group b low: follows the port b polarity bit
	trig_detect #(
		.WIDTH(PBL_WIDTH)
	) u_det_bl (
		.i_sel(sel_b),
		.i_invert(pol_b), // RL4
		.i_level(pbl_lvl),
		.i_rise(pbl_rise),
		.i_fall(pbl_fall),
		.o_trig(trig[2])
	);

	// group b high: shares the code with group b low but is never inverted
	trig_detect #(
		.WIDTH(PBH_WIDTH)
	) u_det_bh (
		.i_sel(sel_b),
		.i_invert(1'b0), // RL5
		.i_level(pbh_lvl),
		.i_rise(pbh_rise),
		.i_fall(pbh_fall),
		.o_trig(trig[3])
	);
	// top-level pin: one edge chosen by its select bit, only while enabled
	assign trig[4] = top_en & (top_rising ? top_rise : top_fall); // RL9 RL10

	////////////////////////////////////////////////////////////////////////////////
	// pending status: set wins over write-one clear; a sensitivity change clears groups
	// in level mode the trigger stays high, so the bit re-sets while the level holds
	wire [NUM_SOURCES-1:0] w1c = wr_stat ? i_req.wdata[NUM_SOURCES-1:0] : '0;
	wire [NUM_SOURCES-1:0] sens_clr = {1'b0, {(NUM_SOURCES-1){sense_changed}}}; // RL11
	assign status_nxt = (status_r & ~w1c & ~sens_clr) | trig;

	////////////////////////////////////////////////////////////////////////////////
	// priority next values
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			prio_nxt[k] = prio_r[k];
		end
		if (wr_prio) begin
			prio_nxt[prio_idx] = prio_filter(prio_r[prio_idx], i_req.wdata); // RL12
		end
		prio_nxt[3] = prio_nxt[3] | PRIO3_FIXED;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux, answered one cycle later
	logic [7:0] rd_mux;
	always_comb begin
		case (i_req.addr)
			OFS_PRIO_0: rd_mux = prio_r[0];
			OFS_PRIO_1: rd_mux = prio_r[1];
			OFS_PRIO_2: rd_mux = prio_r[2];
			OFS_PRIO_3: rd_mux = prio_r[3];
			OFS_CONTROL: rd_mux = control_r; // RL1
			OFS_IRQ_STATUS: rd_mux = 8'(status_r);
			OFS_IRQ_MASK: rd_mux = 8'(mask_r);
			default: rd_mux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			control_r <= CONTROL_RESET; // RL1
		end else begin
			control_r <= control_nxt;
		end
	end

	// sticky pending status
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// interrupt mask, written whole
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			mask_r <= '0;
		end else if (wr_mask) begin
			mask_r <= i_req.wdata[NUM_SOURCES-1:0];
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= i_req.rd ? rd_mux : 8'h00;
		end
	end

	// software priority registers
	always_ff @(posedge i_sys_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (!i_rstn) begin
				prio_r[k] <= PRIO_RESET;
			end else begin
				prio_r[k] <= prio_nxt[k];
			end
		end
	end

	// outputs
	assign o_rdata = rdata_r;
	assign o_pending = status_r;
	assign o_irq = |(status_r & mask_r);
endmodule

// ==== ext_irq_sense_asserts.sv ====
// Purpose: port checks for the external interrupt sensitivity block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design from the bench top file
`timescale 1ns/10ps
module ext_irq_sense_asserts #(
	parameter int PF_WIDTH = 3
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input ext_irq_pkg::reg_req_type i_req,
	input wire logic [7:0] o_rdata,
	input wire logic i_cpu_priority_high_bit,
	input wire logic i_cpu_priority_low_bit,
	input wire logic [PF_WIDTH-1:0] i_portf_pins,
	input wire logic [ext_irq_pkg::NUM_SOURCES-1:0] o_pending,
	input wire logic o_irq
);
	import ext_irq_pkg::*;
	wire logic lvl3 = i_cpu_priority_high_bit & i_cpu_priority_low_bit;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////
	// one-cycle bus strobes aimed at one register
	sequence s_rd(a); i_req.rd && i_req.addr == a; endsequence
	sequence s_wr(a, ok); i_req.wr && i_req.addr == a && ok; endsequence
	property p_rd_idle; !$past(i_req.rd) |-> o_rdata == 8'h00; endproperty
	property p_ctl_wr; s_wr(OFS_CONTROL, lvl3) ##1 s_rd(OFS_CONTROL)
		|=> o_rdata[7:2] == $past(i_req.wdata[7:2], 2); endproperty
	property p_ctl_lock; s_rd(OFS_CONTROL) ##1 s_wr(OFS_CONTROL, !lvl3) ##1 s_rd(OFS_CONTROL)
		|=> o_rdata[7:2] == $past(o_rdata[7:2], 2); endproperty
	property p_prio_take; s_wr(OFS_PRIO_0, i_req.wdata[1:0] != PAIR_LEVEL_0) ##1 s_rd(OFS_PRIO_0)
		|=> o_rdata[1:0] == $past(i_req.wdata[1:0], 2); endproperty
	property p_prio_keep; s_rd(OFS_PRIO_0) ##1 s_wr(OFS_PRIO_0, i_req.wdata[1:0] == PAIR_LEVEL_0)
		##1 s_rd(OFS_PRIO_0) |=> o_rdata[1:0] == $past(o_rdata[1:0], 2); endproperty
	property p_prio3; s_rd(OFS_PRIO_3) |=> o_rdata[7:4] == 4'hf; endproperty
	property p_unmapped; i_req.rd && i_req.addr > OFS_IRQ_MASK |=> o_rdata == 8'h00; endproperty
	property p_irq; o_irq |-> o_pending != '0; endproperty
	property p_sticky; |($past(o_pending) & ~o_pending) |-> $past(i_req.wr)
		&& ($past(i_req.addr) == OFS_IRQ_STATUS || $past(i_req.addr) == OFS_CONTROL); endproperty
	property p_f_cause; $rose(o_pending[1]) |-> $past(i_portf_pins, 2) != '1
		|| $past(i_portf_pins, 3) != '1 || $past(i_portf_pins, 4) != '1; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");
	a_ctl_lock: assert property (p_ctl_lock) else $error("locked control changed");
	a_prio_take: assert property (p_prio_take) else $error("priority pair lost");
	a_prio_keep: assert property (p_prio_keep) else $error("level 0 pair taken");
	a_prio3: assert property (p_prio3) else $error("priority 3 top bits wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_irq: assert property (p_irq) else $error("interrupt without status");
	a_sticky: assert property (p_sticky) else $error("status dropped unasked");
	a_f_cause: assert property (p_f_cause) else $error("port F status without cause");
endmodule

// ==== ext_pin_model.sv ====
// Purpose: far-side model of the external interrupt pins
// Assumes: pins idle high until told otherwise
// Notes: lines move off the clock edge, promptly or some cycles late
`timescale 1ns/10ps
module ext_pin_model (
	input wire logic i_sys_clk,
	input wire logic [15:0] i_target,
	input wire logic [1:0] i_delay,
	output logic [15:0] o_pins
);
	logic [1:0] wait_r = 2'h0;
	// pins follow the request after the chosen delay
	initial o_pins = 16'hffff;
	always @(negedge i_sys_clk) begin
		if (o_pins == i_target) wait_r <= i_delay;
		else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
		else o_pins <= i_target;
	end
endmodule

// ==== ext_irq_sense_tb.sv ====
// Purpose: self-checking bench for the external interrupt sensitivity block
// Assumes: pins come from the partner model, registers from bus tasks
// Notes: a behavioural model predicts every read and the interrupt line
`timescale 1ns/10ps
module ext_irq_sense_tb;
	import ext_irq_pkg::*;
	logic i_sys_clk, i_rstn, hi_bit, lo_bit, o_irq, s, inv;
	reg_req_type i_req;
	logic [7:0] o_rdata, ctrl, mask, d, v;
	logic [7:0] prio [4];
	logic [15:0] target, pins;
	logic [4:0] o_pending, ex;
	logic [1:0] dly, code;
	logic [31:0] seed, r;
	int fail_count, checked, cycles;
	ext_irq_sense dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata),
		.i_cpu_priority_high_bit(hi_bit), .i_cpu_priority_low_bit(lo_bit),
		.i_porta_pins(pins[3:0]), .i_portf_pins(pins[6:4]), .i_portb_low_pins(pins[10:7]),
		.i_portb_high_pins(pins[14:11]), .i_top_pin(pins[15]), .o_pending(o_pending),
		.o_irq(o_irq));
	ext_pin_model pm (.i_sys_clk(i_sys_clk), .i_target(target), .i_delay(dly), .o_pins(pins));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] rexp(input logic [7:0] a);
		if (a[7:2] == 6'h09) return prio[a[1:0]];
		if (a == OFS_CONTROL) return ctrl;
		return (a == OFS_IRQ_MASK) ? mask : 8'h00;
	endfunction
	function automatic logic hit(input logic [1:0] c, input logic iv, input logic e);
		if (c == 2'h0 || c == 2'h3) return 1'b1;
		return ((c == 2'h1) ^ iv) ? e : ~e;
	endfunction
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report();
		if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// bus tasks hold the request until the next task or idle replaces it
	task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic [1:0] l);
		i_req <= {a, x, 2'b10};
		{hi_bit, lo_bit} <= l;
		@(posedge i_sys_clk);
		if (a == OFS_CONTROL) ctrl = {l == LEVEL_3 ? x[7:2] : ctrl[7:2], ctrl[0] ? ctrl[1] : x[1], x[0]};
		if (a == OFS_IRQ_MASK) mask = {3'h0, x[4:0]};
		for (int p = 0; p < 4; p++)
			if (a[7:2] == 6'h09 && x[2*p+:2] != PAIR_LEVEL_0) prio[a[1:0]][2*p+:2] = x[2*p+:2];
		if (a == OFS_PRIO_3) prio[3][7:4] = 4'hf;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		i_req <= {a, 8'h00, 2'b01};
		@(posedge i_sys_clk);
		fork
			#1 check(o_rdata, x);
		join_none
	endtask
	task idle(input int n);
		i_req <= '0;
		repeat (n) @(posedge i_sys_clk);
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			final_report();
		end
	end
	// reset, register traffic, then every trigger code on every group
	initial begin
		{i_rstn, hi_bit, lo_bit, dly, ctrl, mask} = '0;
		i_req = '0;
		target = 16'hffff;
		prio = '{default: 8'hff};
		seed = 32'd19409;
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'h24 + i[7:0], rexp(8'h24 + i[7:0]));
		for (int i = 0; i < 60; i++) begin
			r = xs();
			d = (r[2:0] == 3'h5) ? 8'h2b : 8'h24 + {5'h0, r[2:0]};
			rd(d, rexp(d));
			wr(d, r[15:8], r[17:16]);
			rd(d, rexp(d));
		end
		for (int i = 0; i < 16; i++) begin
			{code, inv, s} = i[3:0];
			r = xs();
			target <= {16{s}};
			dly <= r[1:0];
			idle(10);
			v = {code, inv, code, inv, inv, 1'b0};
			wr(OFS_CONTROL, v, LEVEL_3);
			wr(OFS_CONTROL, v | 8'h01, LEVEL_3);
			wr(OFS_IRQ_STATUS, 8'h1f, LEVEL_3);
			wr(OFS_IRQ_MASK, r[12:5], LEVEL_3);
			target <= {16{~s}};
			idle(10);
			ex = {~s == inv, hit(code, 0, ~s), hit(code, inv, ~s), hit(code, 0, ~s), hit(code, inv, ~s)};
			rd(OFS_IRQ_STATUS, {3'h0, ex});
			idle(2);
			fork
				#1 check({7'h0, o_irq}, {7'h0, |(ex & mask[4:0])});
				#1 check({3'h0, o_pending}, {3'h0, ex});
			join_none
			if (code != 2'h0) begin
				wr(OFS_CONTROL, ctrl ^ 8'h04, LEVEL_3);
				rd(OFS_IRQ_STATUS, {3'h0, ex & 5'h10});
			end
		end
		idle(2);
		final_report();
	end
endmodule
bind ext_irq_sense ext_irq_sense_asserts #(.PF_WIDTH(PF_WIDTH)) u_chk (.i_sys_clk(i_sys_clk),
	.i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata), .i_portf_pins(i_portf_pins),
	.i_cpu_priority_high_bit(i_cpu_priority_high_bit), .o_pending(o_pending),
	.i_cpu_priority_low_bit(i_cpu_priority_low_bit), .o_irq(o_irq));
